/* File: src/btbx_regs.svh */
// Constants for the bit test, toggle and overflow branch executor
`ifndef BTBX_REGS_SVH
`define BTBX_REGS_SVH
// ----------------------------------------
// Encodings
// ----------------------------------------
`define BTBX_OP_SKIPSET 4'hA
`define BTBX_OP_TOGGLE 4'h7
`define BTBX_OP_BRANCH 8'hE4
`define BTBX_IDX_LIMIT 8'h5F
`define BTBX_ACC_SPLIT 8'h60
`define BTBX_ACC_HI_BANK 4'hF
`define BTBX_PHASES 2'h3
`define BTBX_PC_STEP 21'h000002
`endif

/* File: src/btbx_pkg.sv */
// Types for the bit test, toggle and overflow branch executor
package btbx_pkg;
	typedef enum logic [1:0] {
		BTBX_ST_EXEC = 2'b00,
		BTBX_ST_IDLE1 = 2'b01,
		BTBX_ST_IDLE2 = 2'b10
	} btbx_state_t;
endpackage

/* File: src/btbx_phase.sv */
// Four phase generator of the instruction cycle
`timescale 1ns/1ns
`include "btbx_regs.svh"
module btbx_phase (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Phase
	output logic [1:0] phase,
	output logic last
);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end
	assign last = (phase == `BTBX_PHASES);
endmodule

/* File: src/btbx_core.sv */
// Executes skip-if-set, bit invert and branch-on-overflow instructions
`timescale 1ns/1ns
`include "btbx_regs.svh"
module btbx_core
	import btbx_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// Instruction stream
	input wire logic [15:0] INSTR,
	input wire logic INSTR_VALID,
	input wire logic NEXT_TWO_WORD,
	input wire logic EXT_SET_EN,
	input wire logic [7:0] BANK_SELECT_REG,
	input wire logic [11:0] FSR2_BASE,
	input wire logic OVERFLOW,
	input wire logic [20:0] PC_IN,
	// Data memory
	output logic [11:0] DM_ADDR,
	input wire logic [7:0] DM_RDATA,
	output logic [7:0] DM_WDATA,
	output logic DM_WE,
	// Program counter and status
	output logic [20:0] PC_OUT,
	output logic PC_WE,
	output logic CYCLE_END,
	output logic BUSY,
	output logic [1:0] PHASE
);
	// ----------------------------------------
	// Phase counter
	// ----------------------------------------
	logic [1:0] phase;
	logic last;
	btbx_phase u_phase (
		.clk(CLK),
		.rst(SYS_RST),
		.phase(phase),
		.last(last)
	);
	assign PHASE = phase;
	assign CYCLE_END = last;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	btbx_state_t state_reg;
	logic is_skip, is_tog, is_bra, exec;
	logic [2:0] bit_idx;
	logic acc;
	logic [7:0] faddr;
	logic [11:0] eff_addr;
	logic [20:0] target;
	assign exec = INSTR_VALID && (state_reg == BTBX_ST_EXEC);
	assign is_skip = exec && (INSTR[15:12] == `BTBX_OP_SKIPSET);
	assign is_tog = exec && (INSTR[15:12] == `BTBX_OP_TOGGLE);
	assign is_bra = exec && (INSTR[15:8] == `BTBX_OP_BRANCH);
	assign bit_idx = INSTR[11:9];
	assign acc = INSTR[8];
	assign faddr = INSTR[7:0];

	always_comb begin
		if (acc) begin
			eff_addr = {BANK_SELECT_REG[3:0], faddr};
		end else if (EXT_SET_EN && faddr <= `BTBX_IDX_LIMIT) begin
			eff_addr = FSR2_BASE + {4'h0, faddr};
		end else if (faddr < `BTBX_ACC_SPLIT) begin
			eff_addr = {4'h0, faddr};
		end else begin
			eff_addr = {`BTBX_ACC_HI_BANK, faddr};
		end
	end

	assign target = PC_IN + `BTBX_PC_STEP + {{12{INSTR[7]}}, INSTR[7:0], 1'b0};

	// ----------------------------------------
	// Data memory access
	// ----------------------------------------
	logic [7:0] data_reg;
	assign DM_ADDR = eff_addr;
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			data_reg <= 8'h00;
		end else if (phase == 2'h1 && exec) begin
			data_reg <= DM_RDATA;
		end else if (phase == 2'h2 && is_tog) begin
			data_reg <= data_reg ^ (8'h01 << bit_idx);
		end
	end
	// Write lands in Q4 of the same cycle, so the toggle never stretches
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			DM_WE <= 1'b0;
			DM_WDATA <= 8'h00;
		end else begin
			DM_WE <= (phase == 2'h2) && is_tog;
			DM_WDATA <= data_reg ^ (8'h01 << bit_idx);
		end
	end

	// ----------------------------------------
	// Program counter write
	// ----------------------------------------
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			PC_WE <= 1'b0;
			PC_OUT <= 21'h000000;
		end else begin
			PC_WE <= (phase == 2'h2) && is_bra && OVERFLOW;
			PC_OUT <= target;
		end
	end

	// ----------------------------------------
	// Flush sequencer
	// ----------------------------------------
	logic skip_hit;
	assign skip_hit = is_skip && data_reg[bit_idx];
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_reg <= BTBX_ST_EXEC;
		end else if (last) begin
			case (state_reg)
				BTBX_ST_EXEC: begin
					if (skip_hit && NEXT_TWO_WORD) begin
						state_reg <= BTBX_ST_IDLE2;
					end else if (skip_hit || (is_bra && OVERFLOW)) begin
						state_reg <= BTBX_ST_IDLE1;
					end
				end
				BTBX_ST_IDLE2: state_reg <= BTBX_ST_IDLE1;
				default: state_reg <= BTBX_ST_EXEC;
			endcase
		end
	end
	assign BUSY = (state_reg != BTBX_ST_EXEC);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_tog_write;
		@(posedge CLK) disable iff (SYS_RST)
		(phase == 2'h2 && is_tog) |=> DM_WE && DM_WDATA == ($past(DM_RDATA, 2) ^ (8'h01 << bit_idx));
	endproperty
	a_tog_write: assert property (p_tog_write) else $error("toggle write wrong");
	property p_tog_q4;
		@(posedge CLK) disable iff (SYS_RST) DM_WE |-> phase == 2'h3;
	endproperty
	a_tog_q4: assert property (p_tog_q4) else $error("write not in Q4");
	property p_bra_pc;
		@(posedge CLK) disable iff (SYS_RST)
		(phase == 2'h2 && is_bra && OVERFLOW) |=> PC_WE && PC_OUT == $past(target);
	endproperty
	a_bra_pc: assert property (p_bra_pc) else $error("branch target wrong");
	property p_bra_idle;
		@(posedge CLK) disable iff (SYS_RST)
		(last && is_bra && OVERFLOW) |=> BUSY [*4] ##1 !BUSY;
	endproperty
	a_bra_idle: assert property (p_bra_idle) else $error("branch idle wrong");
	property p_nobra;
		@(posedge CLK) disable iff (SYS_RST)
		(is_bra && !OVERFLOW) |-> !PC_WE ##1 !PC_WE;
	endproperty
	a_nobra: assert property (p_nobra) else $error("untaken branch wrote PC");
	property p_skip1;
		@(posedge CLK) disable iff (SYS_RST)
		(last && skip_hit && !NEXT_TWO_WORD) |=> BUSY [*4] ##1 !BUSY;
	endproperty
	a_skip1: assert property (p_skip1) else $error("skip length wrong");
	property p_skip2;
		@(posedge CLK) disable iff (SYS_RST)
		(last && skip_hit && NEXT_TWO_WORD) |=> BUSY [*8] ##1 !BUSY;
	endproperty
	a_skip2: assert property (p_skip2) else $error("two-word skip wrong");
	property p_busy_quiet;
		@(posedge CLK) disable iff (SYS_RST) BUSY |-> !DM_WE && !(phase == 2'h2 && exec);
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("idle cycle active");
	property p_bank;
		@(posedge CLK) disable iff (SYS_RST)
		acc |-> DM_ADDR == {BANK_SELECT_REG[3:0], faddr};
	endproperty
	a_bank: assert property (p_bank) else $error("bank select wrong");
	property p_idx;
		@(posedge CLK) disable iff (SYS_RST)
		(!acc && EXT_SET_EN && faddr <= 8'h5F) |-> DM_ADDR == FSR2_BASE + {4'h0, faddr};
	endproperty
	a_idx: assert property (p_idx) else $error("indexed address wrong");
	// A stretched strobe would write the same location twice
	property p_we_pulse;
		@(posedge CLK) disable iff (SYS_RST) DM_WE |=> !DM_WE;
	endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
	property p_pc_pulse;
		@(posedge CLK) disable iff (SYS_RST) PC_WE |=> !PC_WE;
	endproperty
	a_pc_pulse: assert property (p_pc_pulse) else $error("PC strobe too long");
	// Flushed cycles must leave the program counter alone as well
	property p_busy_no_pc;
		@(posedge CLK) disable iff (SYS_RST) BUSY |-> !PC_WE;
	endproperty
	a_busy_no_pc: assert property (p_busy_no_pc) else $error("PC written while flushing");
	// A clear bit must not cost an extra cycle
	property p_skip_miss;
		@(posedge CLK) disable iff (SYS_RST)
		(last && is_skip && !data_reg[bit_idx]) |=> !BUSY;
	endproperty
	a_skip_miss: assert property (p_skip_miss) else $error("skip taken on clear bit");
	property p_tog_no_pc;
		@(posedge CLK) disable iff (SYS_RST)
		(phase == 2'h2 && is_tog) |=> !PC_WE;
	endproperty
	a_tog_no_pc: assert property (p_tog_no_pc) else $error("toggle touched PC");

	// ----------------------------------------
	// Coverage
	// ----------------------------------------
	c_tog: cover property (@(posedge CLK) DM_WE);
	c_bra: cover property (@(posedge CLK) PC_WE);
	c_skip2: cover property (@(posedge CLK) last && skip_hit && NEXT_TWO_WORD);
	c_skip1: cover property (@(posedge CLK) last && skip_hit && !NEXT_TWO_WORD);
	c_idx: cover property (@(posedge CLK) exec && !acc && EXT_SET_EN && faddr <= 8'h5F);
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the bit test, toggle and overflow branch executor
`timescale 1ns/1ns
module tb_top;
	import btbx_pkg::*;
	// ----------------------------------------
	// Stimulus and wiring
	// ----------------------------------------
	logic CLK = 0, SYS_RST = 1, INSTR_VALID = 0, NEXT_TWO_WORD = 0, EXT_SET_EN = 0, OVERFLOW = 0;
	logic [15:0] INSTR = 16'h0000, w;
	logic [7:0] BANK_SELECT_REG = 8'h00, DM_RDATA = 8'h00, DM_WDATA;
	logic [11:0] FSR2_BASE = 12'h000, DM_ADDR;
	logic [20:0] PC_IN = 21'h000000, PC_OUT;
	logic DM_WE, PC_WE, CYCLE_END, BUSY;
	logic [1:0] PHASE;
	// Values drawn ahead of each instruction, driven once at its Q1 edge
	logic s_ext, s_two, s_ovf;
	logic [7:0] s_rd, s_bsr;
	logic [11:0] s_fsr;
	logic [20:0] s_pc;
	logic [31:0] r;
	int miscompares = 0, samples_checked = 0, seed = 86821, k;
	always #10 CLK = ~CLK;
	btbx_core i_btbx_core (.CLK(CLK), .SYS_RST(SYS_RST), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
		.NEXT_TWO_WORD(NEXT_TWO_WORD), .EXT_SET_EN(EXT_SET_EN), .BANK_SELECT_REG(BANK_SELECT_REG),
		.FSR2_BASE(FSR2_BASE), .OVERFLOW(OVERFLOW), .PC_IN(PC_IN), .DM_ADDR(DM_ADDR),
		.DM_RDATA(DM_RDATA), .DM_WDATA(DM_WDATA), .DM_WE(DM_WE), .PC_OUT(PC_OUT), .PC_WE(PC_WE),
		.CYCLE_END(CYCLE_END), .BUSY(BUSY), .PHASE(PHASE));
	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task chk_d(input logic [20:0] got, input logic [20:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk_b(input logic got, input logic exp);
		chk_d({20'h0, got}, {20'h0, exp});
	endtask
	// Expected effective address of a bit-oriented word
	function logic [11:0] ea(input logic [15:0] x);
		if (x[8])
			return {BANK_SELECT_REG[3:0], x[7:0]};
		if (EXT_SET_EN && x[7:0] <= 8'h5F)
			return FSR2_BASE + {4'h0, x[7:0]};
		return (x[7:0] < 8'h60) ? {4'h0, x[7:0]} : {4'hF, x[7:0]};
	endfunction
	task rnd;
		r = $random(seed);
		s_ext = r[0];
		s_two = r[1];
		s_ovf = r[2];
		s_rd = r[15:8];
		s_bsr = r[23:16];
		r = $random(seed);
		s_fsr = r[11:0];
		s_pc = r[31:11];
	endtask
	// One instruction cycle, then the idle cycles that follow it
	task run(input logic [15:0] x);
		int n;
		logic br, tg, sk;
		logic [20:0] cnt, exp_busy;
		br = (x[15:8] == 8'hE4);
		tg = (x[15:12] == 4'h7);
		sk = (x[15:12] == 4'hA);
		n = 0;
		while (PHASE !== 2'h0 && n < 16) begin
			@(negedge CLK);
			n++;
		end
		EXT_SET_EN = s_ext;
		NEXT_TWO_WORD = s_two;
		OVERFLOW = s_ovf;
		DM_RDATA = s_rd;
		BANK_SELECT_REG = s_bsr;
		FSR2_BASE = s_fsr;
		PC_IN = s_pc;
		INSTR = x;
		INSTR_VALID = 1'h1;
		#1 if (!br) chk_d({9'h0, DM_ADDR}, {9'h0, ea(x)});
		repeat (3) @(negedge CLK);
		chk_b(CYCLE_END, 1'b1);
		chk_b(DM_WE, tg);
		if (tg) chk_d({13'h0, DM_WDATA}, {13'h0, DM_RDATA ^ (8'h01 << x[11:9])});
		chk_b(PC_WE, br && OVERFLOW);
		if (br && OVERFLOW) chk_d(PC_OUT, PC_IN + 21'h2 + {{12{x[7]}}, x[7:0], 1'b0});
		// Valid stays up across the Q4 edge, where the flush is decided
		cnt = 21'h0;
		repeat (8) begin
			@(negedge CLK);
			INSTR_VALID = 1'h0;
			cnt = cnt + {20'h0, BUSY};
		end
		exp_busy = (br && OVERFLOW) ? 21'h4 : 21'h0;
		if (sk && DM_RDATA[x[11:9]])
			exp_busy = NEXT_TWO_WORD ? 21'h8 : 21'h4;
		chk_d(cnt, exp_busy);
		$display("test %h done", x);
	endtask
	task wrap_up;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Sequence: corners first, then random words
	// ----------------------------------------
	initial begin
		#100000;
		miscompares++;
		wrap_up;
	end
	initial begin
		repeat (4) @(posedge CLK);
		@(negedge CLK) SYS_RST = 0;
		rnd;
		s_rd = 8'h75;
		run(16'h7880);
		rnd;
		s_ovf = 1'h1;
		run(16'hE480);
		rnd;
		s_ovf = 1'h1;
		run(16'hE47F);
		rnd;
		s_ovf = 1'h0;
		run(16'hE405);
		rnd;
		s_rd = 8'hFF;
		s_two = 1'h1;
		run(16'hAE5F);
		rnd;
		s_rd = 8'h00;
		run(16'hA05F);
		rnd;
		s_ext = 1'h1;
		run(16'h7060);
		// Last indexed address, and a banked skip over a one-word instruction
		rnd;
		s_ext = 1'h1;
		run(16'h725F);
		rnd;
		s_rd = 8'h01;
		s_two = 1'h0;
		run(16'hA1C3);
		for (k = 0; k < 40; k++) begin
			rnd;
			r = $random(seed);
			w = r[15:0];
			case (r[17:16])
				2'h0: w[15:12] = 4'h7;
				2'h1: w[15:12] = 4'hA;
				default: w[15:8] = 8'hE4;
			endcase
			run(w);
		end
		wrap_up;
	end
endmodule
